//--- bench/blc_plant.sv
/*
 * Behavioural model of the regulator power stage seen by the control block.
 * Assumes the reference code and enable come from the block on ref_clk_i.
 */
`timescale 1ns/1ps
module blc_plant #(
    parameter int SETTLE_CYC = 8
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       regulator_en_i,
    input  wire logic [3:0] output_ref_code_i,
    output logic            vout_settled_o
);
    logic [3:0] last_ref_r;
    int         cnt_r;

    // Output settles a fixed time after the reference stops moving
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_ref_r <= 4'h0;
            cnt_r      <= 0;
        end else begin
            last_ref_r <= output_ref_code_i;
            if (!regulator_en_i || last_ref_r != output_ref_code_i)
                cnt_r <= 0;
            else if (cnt_r < SETTLE_CYC)
                cnt_r <= cnt_r + 1;
        end
    end

    // Drops at once when the reference moves, so no stale settle is seen
    assign vout_settled_o = regulator_en_i && (last_ref_r == output_ref_code_i)
                            && (cnt_r >= SETTLE_CYC);
endmodule

//--- bench/tb.sv
/*
 * Self-checking bench: APB register calls with expected values.
 * Assumes shortened timing parameters and the power stage model.
 */
`timescale 1ns/1ps
module tb;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata_o, q;
    logic        pready_o, pslverr_o, e;
    logic        vbus = 1'b0, cur_lim = 1'b0, vloop = 1'b0, settled;
    logic        alert_o, alert_oe_o, regulator_en_o, sync_rect_en_o, power_valid_flag_o;
    logic [3:0]  output_ref_code_o, bulk_voltage_limit_code_o;
    logic [2:0]  input_current_limit_code_o;
    logic        volt_limit_en_o, limiter_en_o, precharge_en_o, sw_on, uvlo_lo;
    int          fails = 0, tests_run = 0, n;

    always #10 ref_clk_i = ~ref_clk_i;

    blc_ctrl #(.ALERT_PULSE_CYC(16'd20), .CV_QUAL_CYC(16'd40), .SLEW_STEP_CYC(16'd5)) u_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .vbus_start_i(vbus),
        .vout_settled_i(settled), .current_limit_i(cur_lim), .volt_loop_i(vloop),
        .alert_o(alert_o), .alert_oe_o(alert_oe_o), .regulator_en_o(regulator_en_o),
        .output_ref_code_o(output_ref_code_o), .sync_rect_en_o(sync_rect_en_o),
        .power_valid_flag_o(power_valid_flag_o),
        .input_current_limit_code_o(input_current_limit_code_o),
        .bulk_voltage_limit_code_o(bulk_voltage_limit_code_o),
        .volt_limit_en_o(volt_limit_en_o), .limiter_en_o(limiter_en_o),
        .precharge_en_o(precharge_en_o), .bulk_charge_switch_on_o(sw_on),
        .uvlo_low_sel_o(uvlo_lo));

    blc_plant u_plant (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .regulator_en_i(regulator_en_o),
        .output_ref_code_i(output_ref_code_o), .vout_settled_o(settled));

    // Verdict and end of run
    task automatic test_done();
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, values sampled at the pready edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (pready_o !== 1'b1) fails++;
        q = prdata_o;
        e = pslverr_o;
        psel <= 1'b0; penable <= 1'b0;
        // Let the write land before the caller looks at outputs
        @(posedge ref_clk_i);
    endtask

    // Wait for the power-valid flag, n counts cycles
    task automatic wait_pv();
        n = 0;
        while (power_valid_flag_o !== 1'b1 && n < 2000) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 2000) fails++;
    endtask

    // Length of the next alert pulse, 0 if none starts
    task automatic alert_len(output int len);
        int k;
        len = 0;
        for (k = 0; k < 6 && alert_oe_o !== 1'b1; k++) @(posedge ref_clk_i);
        while (alert_oe_o === 1'b1 && len < 100) begin
            @(posedge ref_clk_i);
            len++;
        end
    endtask

    initial begin
        #200us;
        fails++;
        test_done();
    end

    initial begin
        int i, len;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        chk(alert_oe_o, 1); chk(regulator_en_o, 0);
        chk(alert_o, 0);
        apb(8'h04, 1'b0, 32'h0);
        chk(q, 32'h0000_4700);
        repeat (20) @(posedge ref_clk_i);
        chk(regulator_en_o, 0);
        vbus <= 1'b1;
        wait_pv();
        @(posedge ref_clk_i);
        chk(power_valid_flag_o, 1); chk(alert_oe_o, 0); chk(output_ref_code_o, 4'h7);
        apb(8'h00, 1'b0, 32'h0);
        alert_len(len);
        chk(32'(len), 0);
        // Every current and voltage limit code
        for (i = 0; i < 16; i++) begin
            apb(8'h04, 1'b1, 32'h4700 | (i << 4) | (i & 7));
            chk(input_current_limit_code_o, i & 7);
            chk(bulk_voltage_limit_code_o, i); chk(volt_limit_en_o, i != 15);
        end
        apb(8'h04, 1'b1, 32'h5700);
        chk({limiter_en_o, precharge_en_o, regulator_en_o}, 3'b011);
        apb(8'h04, 1'b1, 32'h6700);
        chk({sw_on, uvlo_lo, limiter_en_o, regulator_en_o}, 4'hf);
        apb(8'h04, 1'b1, 32'h0700);
        apb(8'h00, 1'b0, 32'h0);
        alert_len(len);
        chk(32'(len), 20);
        // Upward select step while running
        apb(8'h04, 1'b1, 32'h0900);
        @(posedge ref_clk_i);
        chk(power_valid_flag_o, 0);
        wait_pv();
        chk(n >= 10, 1); chk(output_ref_code_o, 4'h9);
        alert_len(len);
        chk(len > 0, 1);
        // Downward select step
        apb(8'h04, 1'b1, 32'h0300);
        @(posedge ref_clk_i);
        chk({power_valid_flag_o, sync_rect_en_o, output_ref_code_o}, 6'h03);
        wait_pv();
        @(posedge ref_clk_i);
        chk(sync_rect_en_o, 1);
        repeat (40) @(posedge ref_clk_i);
        // Sticky current-limited flag
        cur_lim <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        cur_lim <= 1'b0;
        apb(8'h00, 1'b0, 32'h0);
        chk(q & 32'h6, 32'h2);
        apb(8'h00, 1'b0, 32'h0);
        chk(q & 32'h6, 32'h0);
        // Voltage-limited qualification restarts on re-engage
        vloop <= 1'b1;
        repeat (30) @(posedge ref_clk_i);
        cur_lim <= 1'b1;
        @(posedge ref_clk_i);
        cur_lim <= 1'b0;
        repeat (25) @(posedge ref_clk_i);
        apb(8'h00, 1'b0, 32'h0);
        chk(q & 32'h4, 32'h0);
        repeat (30) @(posedge ref_clk_i);
        apb(8'h00, 1'b0, 32'h0);
        chk(q & 32'h4, 32'h4);
        vloop <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        apb(8'h00, 1'b0, 32'h0);
        chk(q & 32'h4, 32'h0);
        apb(8'h08, 1'b0, 32'h0);
        chk({e, q}, 33'h1_0000_0000);
        test_done();
    end
endmodule

//--- design/blc_ctrl.sv
/*
 * Buck regulator / bulk-node limiter control and status logic with an
 * APB register slave and an open-drain alert pin.
 * Assumes analog status inputs are asynchronous and the APB master runs
 * on ref_clk_i.
 */
// Functional notes
// - Alert held low after power-up; soft-start begins only once supply exceeds 4.4V
// - Alert released high when output first reaches default 3.52V
// - Input current-limit code is 3 bits, codes 0..7 pick sense thresholds
// - Bulk voltage-limit code is 4 bits, 3.00V plus 140mV per step
// - Bulk voltage-limit code 1111 disables voltage limiting
// - Output select is 4 bits, 3.10V plus 60mV per step
// - New output select accepted while running, retargets without restart
// - Upward select change ramps output at 2.4V/ms
// - Upward change clears power-valid, then sets it and pulses alert
// - Downward change: clear flag, lower reference, rectifier off until settled
// - Suspend keeps regulator on, limiter off, precharge path holds bulk node
// - Test mode: bulk switch fully on, lower falling undervoltage threshold
// - Voltage-limited flag live state captured when a status read begins
// - Current-limited flag sticky until host reads status register
// - Voltage-limited flag waits 256us of released current loop
// - Alerts inhibited after reset; else 125us low pulse per flag change
// - Each status register read after start-up gives one alert pulse, none while alerts are inhibited
`timescale 1ns/1ps
module blc_ctrl #(
    parameter logic [15:0] ALERT_PULSE_CYC = blc_pkg::ALERT_PULSE_CYC,
    parameter logic [15:0] CV_QUAL_CYC     = blc_pkg::CV_QUAL_CYC,
    parameter logic [15:0] SLEW_STEP_CYC   = blc_pkg::SLEW_STEP_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        vbus_start_i,
    input  wire logic        vout_settled_i,
    input  wire logic        current_limit_i,
    input  wire logic        volt_loop_i,
    output logic             alert_o,
    output logic             alert_oe_o,
    output logic             regulator_en_o,
    output logic [3:0]       output_ref_code_o,
    output logic             sync_rect_en_o,
    output logic             power_valid_flag_o,
    output logic [2:0]       input_current_limit_code_o,
    output logic [3:0]       bulk_voltage_limit_code_o,
    output logic             volt_limit_en_o,
    output logic             limiter_en_o,
    output logic             precharge_en_o,
    output logic             bulk_charge_switch_on_o,
    output logic             uvlo_low_sel_o
);
    typedef struct packed {
        logic [3:0]       sync1;      // First synchroniser stage
        logic [3:0]       sync2;      // vbus, settled, climit, vloop
        logic             cc_prev;
        blc_pkg::blc_seq_t seq;
        logic             started;
        logic [15:0]      step_cnt;
        logic [15:0]      pulse_cnt;
        logic [15:0]      qual_cnt;
        logic             cv_live;
        logic             cv_cap;
        logic             cc_flag;
        logic [2:0]       input_current_limit_code;
        logic [3:0]       bulk_voltage_limit_code;
        logic [3:0]       output_voltage_select;
        logic             suspend;
        logic             test;
        logic             inhibit;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             alert_oe;
        logic             reg_en;
        logic [3:0]       ref_code;
        logic             sync_rect;
        logic             pv;
        logic             bulk_voltage_limit_code_en;
        logic             limiter_en;
    } blc_state_t;

    blc_state_t st_r;
    blc_state_t st_nxt;

    logic vbus_s;
    logic settled_s;
    logic climit_s;
    logic vloop_s;
    logic access;
    logic done;
    logic is_status;
    logic is_control;
    logic read_done;
    logic ctl_write;
    logic [3:0] new_output_voltage_select;
    logic event_hit;

    // Synchronised inputs and bus decode
    assign vbus_s     = st_r.sync2[0];
    assign settled_s  = st_r.sync2[1];
    assign climit_s   = st_r.sync2[2];
    assign vloop_s    = st_r.sync2[3];
    assign access     = psel_i & penable_i;
    assign done       = access & st_r.pready;
    assign is_status  = paddr_i == blc_pkg::STATUS_REG_OFS;
    assign is_control = paddr_i == blc_pkg::CONTROL_REG_OFS;
    assign read_done  = done & ~pwrite_i & is_status;
    assign ctl_write  = done & pwrite_i & is_control;
    assign new_output_voltage_select   = pwdata_i[blc_pkg::CT_OUTPUT_VOLTAGE_SELECT_LSB +: 4];

    // Next-state logic for the whole block
    always_comb begin
        st_nxt = st_r;
        event_hit = 1'b0;
        st_nxt.sync1 = {volt_loop_i, current_limit_i, vout_settled_i, vbus_start_i};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.cc_prev = climit_s;

        // APB: one wait state, write and read complete on the pready edge
        st_nxt.pready = access & ~st_r.pready;
        st_nxt.pslverr = access & ~st_r.pready & ~is_status & ~is_control;
        if (psel_i & ~penable_i & ~pwrite_i & is_status) begin
            st_nxt.cv_cap = st_r.cv_live;
        end
        if (access & ~st_r.pready) begin
            st_nxt.prdata = 32'h0000_0000;
            if (is_status) begin
                st_nxt.prdata[blc_pkg::ST_PV_BIT] = st_r.pv;
                st_nxt.prdata[blc_pkg::ST_CC_BIT] = st_r.cc_flag;
                st_nxt.prdata[blc_pkg::ST_CV_BIT] = st_r.cv_cap;
            end else if (is_control) begin
                st_nxt.prdata[blc_pkg::CT_INPUT_CURRENT_LIMIT_CODE_LSB +: 3] = st_r.input_current_limit_code;
                st_nxt.prdata[blc_pkg::CT_BULK_VOLTAGE_LIMIT_CODE_LSB +: 4] = st_r.bulk_voltage_limit_code;
                st_nxt.prdata[blc_pkg::CT_OUTPUT_VOLTAGE_SELECT_LSB +: 4] = st_r.output_voltage_select;
                st_nxt.prdata[blc_pkg::CT_SUSPEND_BIT] = st_r.suspend;
                st_nxt.prdata[blc_pkg::CT_TEST_BIT] = st_r.test;
                st_nxt.prdata[blc_pkg::CT_INHIBIT_BIT] = st_r.inhibit;
            end
        end
        if (ctl_write) begin
            st_nxt.input_current_limit_code = pwdata_i[blc_pkg::CT_INPUT_CURRENT_LIMIT_CODE_LSB +: 3];
            st_nxt.bulk_voltage_limit_code = pwdata_i[blc_pkg::CT_BULK_VOLTAGE_LIMIT_CODE_LSB +: 4];
            st_nxt.output_voltage_select = new_output_voltage_select;
            st_nxt.suspend = pwdata_i[blc_pkg::CT_SUSPEND_BIT];
            st_nxt.test = pwdata_i[blc_pkg::CT_TEST_BIT];
            st_nxt.inhibit = pwdata_i[blc_pkg::CT_INHIBIT_BIT];
        end

        if (climit_s) begin
            st_nxt.qual_cnt = 16'h0000;
        end else if (st_r.qual_cnt != CV_QUAL_CYC) begin
            st_nxt.qual_cnt = st_r.qual_cnt + 16'h0001;
        end
        st_nxt.cv_live = vloop_s & ~climit_s & (st_r.qual_cnt == CV_QUAL_CYC);
        // sticky flag, set wins over read clear
        st_nxt.cc_flag = (climit_s & ~st_r.cc_prev) | (st_r.cc_flag & ~read_done);
        st_nxt.bulk_voltage_limit_code_en = st_nxt.bulk_voltage_limit_code != blc_pkg::BULK_VOLTAGE_LIMIT_CODE_NO_LIMIT;
        st_nxt.limiter_en = ~st_nxt.suspend;

        // Regulator sequencing
        st_nxt.step_cnt = 16'h0000;
        unique case (st_r.seq)
            blc_pkg::SEQ_WAIT_VBUS: begin
                st_nxt.ref_code = blc_pkg::OUTPUT_VOLTAGE_SELECT_RST;
                if (vbus_s) begin
                    st_nxt.reg_en = 1'b1;
                    st_nxt.seq = blc_pkg::SEQ_SOFTSTART;
                end
            end
            blc_pkg::SEQ_SOFTSTART: begin
                if (settled_s) begin
                    st_nxt.started = 1'b1;
                    st_nxt.pv = 1'b1;
                    st_nxt.seq = blc_pkg::SEQ_RUN;
                end
            end
            blc_pkg::SEQ_RAMP_UP: begin
                // one code step per slew interval
                st_nxt.step_cnt = st_r.step_cnt + 16'h0001;
                if (st_r.step_cnt == SLEW_STEP_CYC - 16'h0001) begin
                    st_nxt.step_cnt = 16'h0000;
                    st_nxt.ref_code = st_r.ref_code + 4'h1;
                    if (st_r.ref_code + 4'h1 == st_r.output_voltage_select) begin
                        st_nxt.seq = blc_pkg::SEQ_SETTLE_UP;
                    end
                end
            end
            blc_pkg::SEQ_SETTLE_UP: begin
                // set flag once settled, stale settled ignored during sync lag
                st_nxt.step_cnt = st_r.step_cnt;
                if (st_r.step_cnt != blc_pkg::SETTLE_BLANK_CYC) begin
                    st_nxt.step_cnt = st_r.step_cnt + 16'h0001;
                end else if (settled_s) begin
                    st_nxt.pv = 1'b1;
                    st_nxt.seq = blc_pkg::SEQ_RUN;
                end
            end
            blc_pkg::SEQ_DOWN: begin
                // rectifier on once settled, stale settled ignored during sync lag
                st_nxt.step_cnt = st_r.step_cnt;
                if (st_r.step_cnt != blc_pkg::SETTLE_BLANK_CYC) begin
                    st_nxt.step_cnt = st_r.step_cnt + 16'h0001;
                end else if (settled_s) begin
                    st_nxt.sync_rect = 1'b1;
                    st_nxt.pv = 1'b1;
                    st_nxt.seq = blc_pkg::SEQ_RUN;
                end
            end
            blc_pkg::SEQ_RUN: begin
            end
            default: begin
                st_nxt.seq = blc_pkg::SEQ_WAIT_VBUS;
            end
        endcase
        if (st_r.started && st_nxt.output_voltage_select != st_r.output_voltage_select) begin
            st_nxt.pv = 1'b0;
            st_nxt.step_cnt = 16'h0000;
            if (st_nxt.output_voltage_select > st_nxt.ref_code) begin
                st_nxt.seq = blc_pkg::SEQ_RAMP_UP;
                st_nxt.sync_rect = 1'b1;
            end else if (st_nxt.output_voltage_select < st_nxt.ref_code) begin
                st_nxt.ref_code = st_nxt.output_voltage_select;
                st_nxt.sync_rect = 1'b0;
                st_nxt.seq = blc_pkg::SEQ_DOWN;
            end else begin
                st_nxt.seq = blc_pkg::SEQ_SETTLE_UP;
            end
        end

        // alert pulses on flag change or status read
        event_hit = read_done | (st_nxt.pv != st_r.pv) | (st_nxt.cc_flag != st_r.cc_flag)
                  | (st_nxt.cv_live != st_r.cv_live);
        if (st_r.pulse_cnt != 16'h0000) begin
            st_nxt.pulse_cnt = st_r.pulse_cnt - 16'h0001;
        end
        if (event_hit & st_r.started & ~st_r.inhibit) begin
            st_nxt.pulse_cnt = ALERT_PULSE_CYC;
        end
        st_nxt.alert_oe = ~st_nxt.started | (st_nxt.pulse_cnt != 16'h0000);
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.seq <= blc_pkg::SEQ_WAIT_VBUS;
            st_r.input_current_limit_code <= blc_pkg::INPUT_CURRENT_LIMIT_CODE_RST;
            st_r.bulk_voltage_limit_code <= blc_pkg::BULK_VOLTAGE_LIMIT_CODE_RST;
            st_r.output_voltage_select <= blc_pkg::OUTPUT_VOLTAGE_SELECT_RST;
            st_r.ref_code <= blc_pkg::OUTPUT_VOLTAGE_SELECT_RST;
            st_r.inhibit <= 1'b1;
            st_r.sync_rect <= 1'b1;
            st_r.alert_oe <= 1'b1;
            st_r.bulk_voltage_limit_code_en <= 1'b1;
            st_r.limiter_en <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register, except alert_o which is tied low
    assign prdata_o = st_r.prdata;
    assign pready_o = st_r.pready;
    assign pslverr_o = st_r.pslverr;
    assign alert_o = 1'b0;                   // Pin only ever pulled low
    assign alert_oe_o = st_r.alert_oe;
    assign regulator_en_o = st_r.reg_en;
    assign output_ref_code_o = st_r.ref_code;
    assign sync_rect_en_o = st_r.sync_rect;
    assign power_valid_flag_o = st_r.pv;
    assign input_current_limit_code_o = st_r.input_current_limit_code;
    assign bulk_voltage_limit_code_o = st_r.bulk_voltage_limit_code;
    assign volt_limit_en_o = st_r.bulk_voltage_limit_code_en;
    assign limiter_en_o = st_r.limiter_en;
    assign precharge_en_o = st_r.suspend;
    assign bulk_charge_switch_on_o = st_r.test;
    assign uvlo_low_sel_o = st_r.test;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_status_read;
        psel_i && penable_i && pready_o && !pwrite_i && is_status;
    endsequence

    a_alert_boot_low: assert property (!st_r.started |-> alert_oe_o)
        else $error("alert released before start-up");
    a_softstart_gate: assert property ($rose(regulator_en_o) |-> $past(vbus_s))
        else $error("soft-start without supply");
    a_boot_release: assert property ($rose(st_r.started) |-> power_valid_flag_o
        && output_ref_code_o == 4'h7)
        else $error("start-up release wrong");
    a_bulk_voltage_limit_code_nolimit: assert property (bulk_voltage_limit_code_o == 4'hf |-> !volt_limit_en_o)
        else $error("no-limit code still limits");
    a_pv_clear_up: assert property (st_r.started && $changed(st_r.output_voltage_select) |-> !power_valid_flag_o)
        else $error("power-valid kept on select change");
    a_ramp_slow: assert property (st_r.seq == blc_pkg::SEQ_RAMP_UP && $changed(output_ref_code_o)
        |-> $past(st_r.step_cnt) == SLEW_STEP_CYC - 16'h0001)
        else $error("ramp step too early");
    a_down_norect: assert property (st_r.seq == blc_pkg::SEQ_DOWN |-> !sync_rect_en_o)
        else $error("rectifier on during down step");
    a_suspend_mode: assert property (precharge_en_o |-> !limiter_en_o)
        else $error("limiter on in suspend");
    a_test_mode: assert property (bulk_charge_switch_on_o |-> uvlo_low_sel_o)
        else $error("test mode pair mismatch");
    a_cc_sticky: assert property (st_r.cc_flag && !read_done |=> st_r.cc_flag)
        else $error("current flag lost without read");
    a_cv_qualify: assert property (st_r.cv_live |-> $past(st_r.qual_cnt) == CV_QUAL_CYC)
        else $error("voltage flag before release time");
    a_read_alert: assert property (s_status_read ##0 st_r.started && !st_r.inhibit
        |=> alert_oe_o [*2])
        else $error("status read gave no alert");
endmodule

//--- design/blc_pkg.sv
/*
 * Constants for the buck/limiter control and status block: register
 * offsets, field positions, reset values, timing counts, state codes.
 * Assumes a 50 MHz system clock and 32-bit APB data.
 */
package blc_pkg;
    // System clock period
    localparam int CLK_PERIOD_NS = 20;

    // Register byte offsets
    localparam logic [7:0] STATUS_REG_OFS  = 8'h00;
    localparam logic [7:0] CONTROL_REG_OFS = 8'h04;

    // Status register fields
    localparam int ST_PV_BIT = 0;
    localparam int ST_CC_BIT = 1;
    localparam int ST_CV_BIT = 2;

    // Control register fields
    localparam int CT_INPUT_CURRENT_LIMIT_CODE_LSB    = 0;
    localparam int CT_BULK_VOLTAGE_LIMIT_CODE_LSB    = 4;
    localparam int CT_OUTPUT_VOLTAGE_SELECT_LSB    = 8;
    localparam int CT_SUSPEND_BIT = 12;
    localparam int CT_TEST_BIT    = 13;
    localparam int CT_INHIBIT_BIT = 14;

    // Reset values
    localparam logic [2:0] INPUT_CURRENT_LIMIT_CODE_RST = 3'h0;
    localparam logic [3:0] BULK_VOLTAGE_LIMIT_CODE_RST = 4'h0;
    localparam logic [3:0] OUTPUT_VOLTAGE_SELECT_RST = 4'h7;      // 3.52 V start-up level
    localparam logic [3:0] BULK_VOLTAGE_LIMIT_CODE_NO_LIMIT = 4'hf; // Voltage limiting off

    // Times in ns as specified
    localparam int ALERT_PULSE_NS = 125000;
    localparam int CV_QUAL_NS     = 256000;
    localparam int SLEW_STEP_NS   = 25000;   // 60 mV at 2.4 V/ms

    // Derived cycle counts, least times rounded up
    localparam logic [15:0] ALERT_PULSE_CYC =
        16'((ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] CV_QUAL_CYC =
        16'((CV_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] SLEW_STEP_CYC =
        16'((SLEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Cycles the synchronised settled input lags a reference move
    localparam logic [15:0] SETTLE_BLANK_CYC = 16'h0002;

    // Regulator sequencing states
    typedef enum logic [2:0] {
        SEQ_WAIT_VBUS = 3'b000,
        SEQ_SOFTSTART = 3'b001,
        SEQ_RUN       = 3'b010,
        SEQ_RAMP_UP   = 3'b011,
        SEQ_SETTLE_UP = 3'b100,
        SEQ_DOWN      = 3'b101
    } blc_seq_t;
endpackage
